// [hw/cmp_vref_regs.vh]
// Register map, field positions and reset values
// for the comparator reference control block; included by the edge detector and the top in hw.
`ifndef CMP_VREF_REGS_VH
`define CMP_VREF_REGS_VH

// Reference keeps its register index; its byte address is four times it
`define IDX_REF_SETUP  12'hF53
`define A_REF_SETUP    14'h3D4C
`define A_CMP0_SETUP   14'h0000
`define A_CMP1_SETUP   14'h0004
`define A_CMP2_SETUP   14'h0008
`define A_CMP_OUTPUTS  14'h000C
`define A_IRQ_STATUS   14'h0010
`define A_IRQ_MASK     14'h0014
`define A_SLEEP_CTRL   14'h0018

`define RST_SETUP      8'h00
`define RST_WORD       32'h0000_0000
`define RST_ZERO3      3'h0

// Reference setup fields
`define F_LADDER_ON    7
`define F_LEVEL_PIN    6
`define F_RANGE        5
`define F_SUPPLY       4
`define F_TAP_HI       3
`define F_TAP_LO       0

// Comparator setup fields
`define F_CMP_ON       7
`define F_CMP_PIN      6
`define F_CMP_INV      5
`define F_EDGE_HI      4
`define F_EDGE_LO      3
`define F_PLUS         2
`define F_MINUS_HI     1
`define F_MINUS_LO     0

`define EDGE_NONE      2'h0
`define EDGE_RISE      2'h1
`define EDGE_FALL      2'h2
`define EDGE_ANY       2'h3

`define NUM_CMP        3
`define SLEEP_BIT      0
`endif

// [hw/cmp_edge_detect.v]
// One comparator's output path: polarity, level register and edge event.
// Assumes a raw comparator level already synchronous to the clock.
`timescale 1ns/1ps
`include "cmp_vref_regs.vh"
module cmp_edge_detect
(
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_nrst,
    // Setup
    input  wire       i_enable,
    input  wire       i_invert,
    input  wire [1:0] i_edge,
    // Raw level
    input  wire       i_raw,
    // Results
    output reg        o_level,
    output wire       o_event
);
    reg  prev_ff;
    wire cur  = i_enable & (i_raw ^ i_invert);
    wire rise = cur & ~prev_ff;
    wire fall = ~cur & prev_ff;

    // No clock gating here, so detection keeps running in sleep
    always @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            prev_ff <= 1'b0;
            o_level <= 1'b0;
        end
        else
        begin
            prev_ff <= cur;
            o_level <= cur;
        end
    end

    assign o_event = i_enable &
                     (((i_edge == `EDGE_RISE) & rise) |
                      ((i_edge == `EDGE_FALL) & fall) |
                      ((i_edge == `EDGE_ANY)  & (rise | fall)));
endmodule

// [hw/apb_byte_slave.v]
// APB slave front end: one-wait-state-free decode of word accesses.
// Assumes a standard APB master; answers in the access cycle.
`timescale 1ns/1ps
module apb_byte_slave
(
    // APB
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [13:0] i_paddr,
    // Decoded strobes
    output wire        o_wr,
    output wire        o_rd,
    output wire [13:0] o_addr
);
    // Write in access phase only, so it lands exactly once; read in setup phase
    assign o_wr   = i_psel & i_penable & i_pwrite;
    assign o_rd   = i_psel & ~i_penable & ~i_pwrite;
    assign o_addr = i_paddr;
endmodule

// [hw/cmp_vref_ctrl.v]
// Top: comparator and voltage reference digital control with APB.
// Assumes analog comparators give levels synchronous to I_CLK_SYS.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "cmp_vref_regs.vh"
module cmp_vref_ctrl
(
    // Clock and reset
    input  wire        I_CLK_SYS,
    input  wire        I_NRST,
    // APB
    input  wire        I_PSEL,
    input  wire        I_PENABLE,
    input  wire        I_PWRITE,
    input  wire [13:0] I_PADDR,
    input  wire [31:0] I_PWDATA,
    output reg  [31:0] O_PRDATA,
    output wire        O_PREADY,
    output reg         O_PSLVERR,
    // Analog comparator levels
    input  wire [2:0]  I_CMP_RAW,
    // Ladder controls
    output reg         O_LADDER_ON,
    output reg         O_LEVEL_TO_PIN,
    output reg         O_RANGE_SELECT,
    output reg         O_SUPPLY_SOURCE_SELECT,
    output reg  [3:0]  O_TAP_VALUE,
    // Comparator controls
    output reg  [2:0]  O_CMP_ON,
    output reg  [2:0]  O_CMP_PIN_DRIVE,
    output reg  [2:0]  O_PLUS_INPUT_SELECT,
    output reg  [5:0]  O_MINUS_INPUT_SELECT,
    output reg  [2:0]  O_CMP_OUT,
    // Sleep and interrupt
    output reg         O_WAKE,
    output reg         O_IRQ
);
    reg  [7:0]  ref_setup_ff;
    reg  [7:0]  cmp_setup_ff [0:2];
    reg  [2:0]  irq_status_ff;
    reg  [2:0]  irq_mask_ff;
    reg         sleep_ff;
    wire        wr;
    wire        rd;
    wire [13:0] addr;
    wire [2:0]  level;
    wire [2:0]  evt;
    reg  [2:0]  nxt_status;
    reg  [31:0] nxt_rdata;
    reg         nxt_err;
    reg  [7:0]  nxt_ref;
    reg  [23:0] nxt_cmp;
    integer     k;

    function is_mapped;
        input [13:0] a;
        begin
            is_mapped = (a == `A_REF_SETUP)  | (a == `A_CMP0_SETUP) |
                        (a == `A_CMP1_SETUP) | (a == `A_CMP2_SETUP) |
                        (a == `A_CMP_OUTPUTS) | (a == `A_IRQ_STATUS) |
                        (a == `A_IRQ_MASK)   | (a == `A_SLEEP_CTRL);
        end
    endfunction

    apb_byte_slave u_apb
    (
        .i_psel    (I_PSEL),
        .i_penable (I_PENABLE),
        .i_pwrite  (I_PWRITE),
        .i_paddr   (I_PADDR),
        .o_wr      (wr),
        .o_rd      (rd),
        .o_addr    (addr)
    );

    genvar g;
    generate
        for (g = 0; g < `NUM_CMP; g = g + 1)
        begin : g_cmp
            cmp_edge_detect u_edge
            (
                .i_clk    (I_CLK_SYS),
                .i_nrst   (I_NRST),
                .i_enable (cmp_setup_ff[g][`F_CMP_ON]),
                .i_invert (cmp_setup_ff[g][`F_CMP_INV]),
                .i_edge   (cmp_setup_ff[g][`F_EDGE_HI:`F_EDGE_LO]),
                .i_raw    (I_CMP_RAW[g]),
                .o_level  (level[g]),
                .o_event  (evt[g])
            );
        end
    endgenerate

    // Zero-wait slave
    assign O_PREADY = 1'b1;

    // Registers; sleep touches none but sleep_ff, cleared at wake-up
    always @(posedge I_CLK_SYS or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            ref_setup_ff    <= `RST_SETUP;
            cmp_setup_ff[0] <= `RST_SETUP;
            cmp_setup_ff[1] <= `RST_SETUP;
            cmp_setup_ff[2] <= `RST_SETUP;
            irq_mask_ff     <= `RST_ZERO3;
            sleep_ff        <= 1'b0;
        end
        else if (wr)
        begin
            // Setup holds unless written, also across wake-up
            if (addr == `A_REF_SETUP)
                ref_setup_ff <= I_PWDATA[7:0];
            if (addr == `A_CMP0_SETUP)
                cmp_setup_ff[0] <= I_PWDATA[7:0];
            if (addr == `A_CMP1_SETUP)
                cmp_setup_ff[1] <= I_PWDATA[7:0];
            if (addr == `A_CMP2_SETUP)
                cmp_setup_ff[2] <= I_PWDATA[7:0];
            if (addr == `A_IRQ_MASK)
                irq_mask_ff <= I_PWDATA[2:0];
            if (addr == `A_SLEEP_CTRL)
                sleep_ff <= I_PWDATA[`SLEEP_BIT];
        end
        else if (sleep_ff && |(irq_status_ff & irq_mask_ff))
            sleep_ff <= 1'b0;
    end

    // Sticky status; a new event beats write-one-to-clear
    always @*
    begin
        nxt_status = irq_status_ff;
        if (wr && addr == `A_IRQ_STATUS)
            nxt_status = nxt_status & ~I_PWDATA[2:0];
        nxt_status = nxt_status | evt;
    end

    // Controls take a written value at the write edge itself
    always @*
    begin
        nxt_ref = ref_setup_ff;
        nxt_cmp = {cmp_setup_ff[2], cmp_setup_ff[1], cmp_setup_ff[0]};
        if (wr && addr == `A_REF_SETUP)
            nxt_ref = I_PWDATA[7:0];
        if (wr && addr == `A_CMP0_SETUP)
            nxt_cmp[7:0] = I_PWDATA[7:0];
        if (wr && addr == `A_CMP1_SETUP)
            nxt_cmp[15:8] = I_PWDATA[7:0];
        if (wr && addr == `A_CMP2_SETUP)
            nxt_cmp[23:16] = I_PWDATA[7:0];
    end

    always @*
    begin
        nxt_rdata = `RST_WORD;
        case (addr)
            `A_REF_SETUP:   nxt_rdata[7:0] = ref_setup_ff;
            `A_CMP0_SETUP:  nxt_rdata[7:0] = cmp_setup_ff[0];
            `A_CMP1_SETUP:  nxt_rdata[7:0] = cmp_setup_ff[1];
            `A_CMP2_SETUP:  nxt_rdata[7:0] = cmp_setup_ff[2];
            `A_CMP_OUTPUTS: nxt_rdata[2:0] = level;
            `A_IRQ_STATUS:  nxt_rdata[2:0] = irq_status_ff;
            `A_IRQ_MASK:    nxt_rdata[2:0] = irq_mask_ff;
            `A_SLEEP_CTRL:  nxt_rdata[0]   = sleep_ff;
            default:        nxt_rdata      = `RST_WORD;
        endcase
        nxt_err = I_PSEL & ~I_PENABLE & ~is_mapped(addr);
    end

    always @(posedge I_CLK_SYS or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            irq_status_ff          <= `RST_ZERO3;
            O_PRDATA               <= `RST_WORD;
            O_PSLVERR              <= 1'b0;
            O_LADDER_ON            <= 1'b0;
            O_LEVEL_TO_PIN         <= 1'b0;
            O_RANGE_SELECT         <= 1'b0;
            O_SUPPLY_SOURCE_SELECT <= 1'b0;
            O_TAP_VALUE            <= 4'h0;
            O_CMP_ON               <= `RST_ZERO3;
            O_CMP_PIN_DRIVE        <= `RST_ZERO3;
            O_PLUS_INPUT_SELECT    <= `RST_ZERO3;
            O_MINUS_INPUT_SELECT   <= 6'h00;
            O_CMP_OUT              <= `RST_ZERO3;
            O_WAKE                 <= 1'b0;
            O_IRQ                  <= 1'b0;
        end
        else
        begin
            irq_status_ff <= nxt_status;
            // Read data latched in setup, held through access
            if (rd)
                O_PRDATA <= nxt_rdata;
            if (I_PSEL && !I_PENABLE)
                O_PSLVERR <= nxt_err;
            // Ladder mirrors its register, so no extra cycle of lag
            O_LADDER_ON    <= nxt_ref[`F_LADDER_ON];
            O_LEVEL_TO_PIN <= nxt_ref[`F_LEVEL_PIN];
            O_RANGE_SELECT <= nxt_ref[`F_RANGE];
            O_SUPPLY_SOURCE_SELECT <= nxt_ref[`F_SUPPLY];
            O_TAP_VALUE <= nxt_ref[`F_TAP_HI:`F_TAP_LO];
            for (k = 0; k < `NUM_CMP; k = k + 1)
            begin
                O_CMP_ON[k]            <= nxt_cmp[8*k+`F_CMP_ON];
                O_CMP_PIN_DRIVE[k]     <= nxt_cmp[8*k+`F_CMP_PIN];
                O_PLUS_INPUT_SELECT[k] <= nxt_cmp[8*k+`F_PLUS];
                O_MINUS_INPUT_SELECT[2*k +: 2] <=
                    nxt_cmp[8*k+`F_MINUS_LO +: 2];
            end
            O_CMP_OUT <= level;
            // Wake pulses while asleep and an unmasked flag is up
            O_WAKE <= sleep_ff & |(nxt_status & irq_mask_ff);
            O_IRQ  <= |(nxt_status & irq_mask_ff);
        end
    end
endmodule

// [sim/cmp_analog_model.sv]
// Analog side model: comparators feeding raw levels to the block.
// Assumes the bench sets the wanted level of each comparator.
`timescale 1ns/1ps
module cmp_analog_model
(
    // Clock and controls
    input  wire       i_clk,
    input  wire [2:0] i_cmp_on,
    input  wire [2:0] i_want,
    // Raw levels
    output reg  [2:0] o_raw = 3'h0
);
    reg t_ff = 1'b0;
    // An unpowered comparator gives no steady level
    always @(posedge i_clk)
    begin
        t_ff <= ~t_ff;
        o_raw <= (i_want & i_cmp_on) | ({3{t_ff}} & ~i_cmp_on);
    end
endmodule

// [sim/cmp_vref_ctrl_checker.sv]
// Checker for the comparator reference control block.
// Bound to the top module; sees its ports only.
`timescale 1ns/1ps
`include "cmp_vref_regs.vh"
module cmp_vref_ctrl_checker
(
    // Watched ports
    input wire        I_CLK_SYS,
    input wire        I_NRST,
    input wire        I_PSEL,
    input wire        I_PENABLE,
    input wire        I_PWRITE,
    input wire [13:0] I_PADDR,
    input wire [31:0] I_PWDATA,
    input wire        O_LADDER_ON,
    input wire        O_LEVEL_TO_PIN,
    input wire        O_RANGE_SELECT,
    input wire        O_SUPPLY_SOURCE_SELECT,
    input wire [3:0]  O_TAP_VALUE,
    input wire [2:0]  O_CMP_ON,
    input wire [5:0]  O_MINUS_INPUT_SELECT,
    input wire        O_WAKE,
    input wire        O_IRQ
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_NRST);
    wire       wr = I_PSEL & I_PENABLE & I_PWRITE;
    wire       wref = wr & (I_PADDR == `A_REF_SETUP);
    wire [7:0] lad = {O_LADDER_ON, O_LEVEL_TO_PIN, O_RANGE_SELECT,
                      O_SUPPLY_SOURCE_SELECT, O_TAP_VALUE};
    ladder_power_a:
        assert property (wref |=> lad[7] == $past(I_PWDATA[7]))
        else $error("ladder power bit wrong");
    level_pin_a:
        assert property (wref ##1 1'b1 |-> lad[6] == $past(I_PWDATA[6]))
        else $error("pin drive bit wrong");
    range_sel_a:
        assert property (wref |=> O_RANGE_SELECT == $past(I_PWDATA[5]))
        else $error("range bit wrong");
    supply_sel_a:
        assert property (wref |=> lad[4] == $past(I_PWDATA[4]))
        else $error("supply bit wrong");
    tap_value_a:
        assert property (wref |=> O_TAP_VALUE == $past(I_PWDATA[3:0]))
        else $error("tap value wrong");
    ladder_hold_a:
        assert property (!wref |=> $stable(lad))
        else $error("ladder controls moved");
    reset_clear_a:
        // Outputs may be unknown before the first edge inside reset
        assert property (disable iff (1'b0)
            !I_NRST ##1 !I_NRST |->
            lad == 8'h00 && O_CMP_ON == 3'h0 && !O_IRQ)
        else $error("outputs not cleared");
    cmp_setup_a:
        assert property (wr && I_PADDR == `A_CMP0_SETUP |=>
            {O_CMP_ON[0], O_MINUS_INPUT_SELECT[1:0]} ==
            {$past(I_PWDATA[7]), $past(I_PWDATA[1:0])})
        else $error("comparator setup wrong");
    wake_irq_a:
        assert property (O_WAKE |-> O_IRQ)
        else $error("wake without interrupt");
    cover property (wref ##1 O_LADDER_ON);
    cover property ($rose(O_IRQ));
    cover property ($rose(O_WAKE));
endmodule
bind cmp_vref_ctrl cmp_vref_ctrl_checker i_chk (.*);

// [sim/cmp_vref_ctrl_test.sv]
// Bench for the comparator reference control block over APB.
// Assumes a zero-wait slave and the analog model beside it.
`timescale 1ns/1ps
`include "cmp_vref_regs.vh"
module cmp_vref_ctrl_test;
    reg         clk = 1'b0;
    reg         nrst = 1'b0;
    reg         psel = 1'b0;
    reg         pen = 1'b0;
    reg         pwr = 1'b0;
    reg  [13:0] pa = 14'h0000;
    reg  [31:0] pwd = 32'h0;
    reg  [2:0]  want = 3'h0;
    reg  [31:0] rd;
    reg         se;
    reg         woke = 1'b0;
    reg  [7:0]  d;
    wire [31:0] prd;
    wire        rdy, err, lon, lpin, rng, sup, wake, irq;
    wire [3:0]  tap;
    wire [2:0]  on3, cpd, cpl, cout, raw;
    wire [5:0]  cmi;
    wire [7:0]  lad = {lon, lpin, rng, sup, tap};
    integer     fails = 0;
    integer     total_checks = 0;
    integer     k, j;
    always #5 clk = ~clk;
    always @(posedge clk)
        if (wake === 1'b1)
            woke <= 1'b1;
    cmp_vref_ctrl i_cmp_vref_ctrl (.I_CLK_SYS(clk), .I_NRST(nrst),
        .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa),
        .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err),
        .I_CMP_RAW(raw), .O_LADDER_ON(lon), .O_LEVEL_TO_PIN(lpin),
        .O_RANGE_SELECT(rng), .O_SUPPLY_SOURCE_SELECT(sup),
        .O_TAP_VALUE(tap), .O_CMP_ON(on3), .O_CMP_PIN_DRIVE(cpd),
        .O_PLUS_INPUT_SELECT(cpl), .O_MINUS_INPUT_SELECT(cmi),
        .O_CMP_OUT(cout), .O_WAKE(wake), .O_IRQ(irq));
    cmp_analog_model i_cmp_analog_model (.i_clk(clk), .i_cmp_on(on3),
        .i_want(want), .o_raw(raw));
    task xfer(input [13:0] a, input w, input [31:0] v);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pa <= a;
            pwr <= w;
            pwd <= v;
            @(posedge clk);
            pen <= 1'b1;
            @(posedge clk);
            while (rdy !== 1'b1)
                @(posedge clk);
            rd = prd;
            se = err;
            psel <= 1'b0;
            pen <= 1'b0;
        end
    endtask
    task cmp(input [8*10:1] nm, input [31:0] e, input [31:0] g);
        begin
            total_checks = total_checks + 1;
            if (g !== e)
            begin
                fails = fails + 1;
                $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task summarize;
        begin
            $display("checks %0d fails %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task wait_ev;
        begin
            repeat (6) @(posedge clk);
            @(negedge clk);
        end
    endtask
    initial
    begin
        #100000;
        fails = fails + 1;
        summarize;
    end
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        xfer(`A_REF_SETUP, 1'b0, 0);
        cmp("ref rst", 0, rd);
        for (k = 0; k < 3; k = k + 1)
        begin
            xfer(`A_CMP0_SETUP + 4 * k, 1'b0, 0);
            cmp("cmp rst", 0, rd);
        end
        cmp("out rst", 0, {lad, on3, cpd, wake, irq});
        $display("reset test done");
        for (k = 0; k < 9; k = k + 1)
        begin
            d = (k == 8) ? 8'hFF : 8'h80 >> k;
            xfer(`A_REF_SETUP, 1'b1, d);
            @(negedge clk);
            cmp("ladder", d, lad);
            xfer(`A_REF_SETUP, 1'b0, 0);
            cmp("ref rd", d, rd);
        end
        $display("reference test done");
        for (k = 0; k < 3; k = k + 1)
        begin
            d = 8'hC5 ^ (k << 1);
            xfer(`A_CMP0_SETUP + 4 * k, 1'b1, d);
            @(negedge clk);
            cmp("cmp ctl", {d[7], d[6], d[2], d[1:0]},
                {on3[k], cpd[k], cpl[k], cmi[2*k+:2]});
            xfer(`A_CMP0_SETUP + 4 * k, 1'b0, 0);
            cmp("cmp rd", d, rd);
        end
        $display("comparator test done");
        xfer(`A_IRQ_MASK, 1'b1, 1);
        for (k = 0; k < 4; k = k + 1)
        begin
            xfer(`A_CMP0_SETUP, 1'b1, 8'h80 | (k << 3));
            xfer(`A_IRQ_STATUS, 1'b1, 7);
            for (j = 0; j < 2; j = j + 1)
            begin
                want[0] <= (j == 0);
                wait_ev;
                cmp("irq", k[j], irq);
                xfer(`A_IRQ_STATUS, 1'b0, 0);
                cmp("status", k[j], rd);
                xfer(`A_IRQ_STATUS, 1'b1, 1);
            end
        end
        $display("event test done");
        xfer(`A_REF_SETUP, 1'b1, 8'h9A);
        xfer(`A_IRQ_MASK, 1'b1, 0);
        xfer(`A_CMP2_SETUP, 1'b1, 8'h41);
        xfer(`A_SLEEP_CTRL, 1'b1, 1);
        want[0] <= 1'b1;
        wait_ev;
        cmp("masked", 0, {woke, irq, cout[0]} ^ 3'h1);
        xfer(`A_IRQ_MASK, 1'b1, 1);
        wait_ev;
        cmp("woke", 1, woke);
        xfer(`A_CMP_OUTPUTS, 1'b0, 0);
        cmp("outputs", 1, rd);
        xfer(`A_CMP0_SETUP, 1'b1, 8'hA0);
        xfer(`A_CMP_OUTPUTS, 1'b0, 0);
        cmp("inverted", 0, rd);
        xfer(`A_REF_SETUP, 1'b0, 0);
        cmp("ref kept", 8'h9A, rd);
        xfer(`A_CMP1_SETUP, 1'b0, 0);
        cmp("cmp kept", 8'hC7, rd);
        xfer(`A_CMP2_SETUP, 1'b0, 0);
        cmp("cmp2 kept", 8'h41, rd);
        $display("sleep test done");
        xfer(14'h0020, 1'b1, 32'hFF);
        cmp("slverr", 1, se);
        xfer(14'h0020, 1'b0, 0);
        cmp("unmapped", 0, rd);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        xfer(`A_REF_SETUP, 1'b0, 0);
        cmp("ref rst2", 0, rd);
        xfer(`A_CMP0_SETUP, 1'b0, 0);
        cmp("cmp rst2", 0, rd);
        $display("refusal and reset test done");
        summarize;
    end
endmodule
